// >>> hdl/wdg_pkg.sv
/*
 * Package for the windowed reset watchdog: control register layout, reset value,
 * prescaler length and reset pulse timing.
 * Assumes a single 125 MHz clock that also serves as the internal oscillator clock.
 */
package wdg_pkg;
	localparam logic [7:0]  CTRL_ADDR      = 8'h00;
	localparam int          ACT_BIT        = 7;
	localparam int          TOP_BIT        = 6;
	localparam logic [7:0]  CTRL_RESET     = 8'h7f;
	localparam int          PRESCALE_LEN   = 16384;
	localparam int          CLK_PERIOD_PS  = 8000;
	localparam int          PULSE_TIME_NS  = 30000;
	localparam int          PULSE_CYCLES   = (PULSE_TIME_NS * 1000) / CLK_PERIOD_PS;
endpackage

// >>> hdl/windowed_reset_watchdog.sv
/*
 * Windowed reset watchdog: a free-running 7-bit down-counter, stepped by a
 * prescaler, that pulls the chip reset low when its top bit clears while active.
 * Assumes synchronous register strobes and option levels that are stable.
 */
// Notes on behaviour
// - Seven-bit counter plus separate activation bit in control register.
// - Counter steps down once every 16384 oscillator cycles, prescaler free-running.
// - Six low counter bits set timeout in 64 steps.
// - Active counter passing 40h to 3Fh starts a reset cycle.
// - Reset cycle drives reset pin low for about 30 us.
// - Counter keeps decrementing even when watchdog is not active.
// - Register writes never reset the prescaler; timeout varies by phase.
// - After any reset the activation bit is clear.
// - Once active, software cannot clear activation; only reset can.
// - Write setting activation with top bit clear resets immediately.
// - Halt instruction while active resets, if the halt option allows.
// - Option input selects whether halt triggers a reset.
// - Option input selects hardware watchdog mode.
// - Hardware mode treats watchdog as always active, ignoring activation bit.
// - Activation at bit 7, counter bits 6..0, reset value 7Fh.
`timescale 1ns/1ps
module windowed_reset_watchdog #(
	parameter int PRESCALE = wdg_pkg::PRESCALE_LEN,  // Oscillator cycles per counter step.
	parameter int PULSE    = wdg_pkg::PULSE_CYCLES   // Reset pulse length in cycles.
) (
	input  wire logic       mclk,              // Internal oscillator clock.
	input  wire logic       reset_n,           // Asynchronous system reset.
	input  wire logic [7:0] regAddr,           // Register address.
	input  wire logic [7:0] regWdata,          // Register write data.
	input  wire logic       regWrite,          // Write strobe.
	input  wire logic       regRead,           // Read strobe.
	output logic      [7:0] regRdata,          // Read data, one cycle after strobe.
	input  wire logic       haltExec,          // Pulse: halt instruction executed.
	input  wire logic       halt_reset_option, // Option: halt causes reset when active.
	input  wire logic       hwWatchdog,        // Option: watchdog always active.
	output logic            resetPinOut_n,     // Low while the reset pulse runs.
	output logic            resetPinOe         // High while the reset pin is driven.
);
	localparam int PW = $clog2(PRESCALE);
	localparam int CW = $clog2(PULSE + 1);

	logic [PW-1:0] prescale_q;
	logic [6:0]    counter_q;
	logic          watchdog_activate_q;
	logic          topPrev_q;
	logic [CW-1:0] pulseCnt_q;
	logic          step;
	logic          ctrlWrite;
	logic          active;
	logic          timeoutReq;
	logic          softReq;
	logic          haltReq;
	logic          resetReq;

	assign ctrlWrite = regWrite && (regAddr == wdg_pkg::CTRL_ADDR);
	assign step      = (prescale_q == PW'(PRESCALE - 1));
	assign active    = watchdog_activate_q || hwWatchdog;

	// The prescaler is never cleared by software, so a refresh lands at an
	// unknown phase and the timeout spans one step of uncertainty.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			prescale_q <= '0;
		end else if (step) begin
			prescale_q <= '0;
		end else begin
			prescale_q <= prescale_q + PW'(1);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			counter_q <= wdg_pkg::CTRL_RESET[6:0];
		end else if (ctrlWrite) begin
			counter_q <= regWdata[6:0];
		end else if (step) begin
			counter_q <= counter_q - 7'h01;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_activate_q <= 1'b0;
		end else if (ctrlWrite && regWdata[wdg_pkg::ACT_BIT]) begin
			watchdog_activate_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			topPrev_q <= 1'b1;
		end else begin
			topPrev_q <= counter_q[wdg_pkg::TOP_BIT];
		end
	end

	// A soft reset write is acted on at once, even when the top bit was already
	// clear; the falling edge it may cause a cycle later lands inside the pulse.
	assign timeoutReq = active && topPrev_q && !counter_q[wdg_pkg::TOP_BIT];
	assign softReq    = ctrlWrite && regWdata[wdg_pkg::ACT_BIT]
		&& !regWdata[wdg_pkg::TOP_BIT];
	assign haltReq    = active && haltExec && halt_reset_option;
	assign resetReq   = timeoutReq || softReq || haltReq;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pulseCnt_q <= '0;
		end else if (pulseCnt_q != '0) begin
			pulseCnt_q <= pulseCnt_q - CW'(1);
		end else if (resetReq) begin
			pulseCnt_q <= CW'(PULSE);
		end
	end

	// The pin is open drain: it is driven only while pulling low.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			resetPinOut_n <= 1'b1;
			resetPinOe    <= 1'b0;
		end else begin
			resetPinOut_n <= !(resetReq || pulseCnt_q > CW'(1));
			resetPinOe    <= resetReq || pulseCnt_q > CW'(1);
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			regRdata <= 8'h00;
		end else if (regRead && regAddr == wdg_pkg::CTRL_ADDR) begin
			regRdata <= {watchdog_activate_q, counter_q};
		end else begin
			regRdata <= 8'h00;
		end
	end

	// Pulse length held low for exactly PULSE cycles after the request.
	int lowCount;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lowCount <= 0;
		end else if (resetPinOe) begin
			lowCount <= lowCount + 1;
		end else begin
			lowCount <= 0;
		end
	end

	pulse_len_a : assert property (@(posedge mclk) disable iff (!reset_n)
		$fell(resetPinOe) |-> $past(lowCount) == PULSE - 1)
		else $error("reset pulse length wrong");

	timeout_fire_a : assert property (@(posedge mclk) disable iff (!reset_n)
		(active && $fell(counter_q[6])) |=> !resetPinOut_n)
		else $error("timeout did not pull reset");

	no_fire_idle_a : assert property (@(posedge mclk) disable iff (!reset_n)
		(!hwWatchdog && !watchdog_activate_q && !haltExec && !resetPinOe
		 && pulseCnt_q == '0) |=> !resetPinOe)
		else $error("reset while inactive");

	sticky_act_a : assert property (@(posedge mclk) disable iff (!reset_n)
		watchdog_activate_q |=> watchdog_activate_q)
		else $error("activation bit cleared");

	step_dec_a : assert property (@(posedge mclk) disable iff (!reset_n)
		(step && !ctrlWrite) |=> counter_q == $past(counter_q) - 7'h01)
		else $error("counter did not step");

	hold_count_a : assert property (@(posedge mclk) disable iff (!reset_n)
		(!step && !ctrlWrite) |=> counter_q == $past(counter_q))
		else $error("counter moved between steps");

	write_load_a : assert property (@(posedge mclk) disable iff (!reset_n)
		ctrlWrite |=> counter_q == $past(regWdata[6:0]))
		else $error("write not loaded");

	prescale_run_a : assert property (@(posedge mclk) disable iff (!reset_n)
		ctrlWrite && !step |=> prescale_q == $past(prescale_q) + PW'(1))
		else $error("prescaler disturbed by write");

	halt_reset_a : assert property (@(posedge mclk) disable iff (!reset_n)
		(haltExec && halt_reset_option && active) |=> resetPinOe)
		else $error("halt did not reset");

	soft_reset_a : assert property (@(posedge mclk) disable iff (!reset_n)
		(ctrlWrite && regWdata[7] && !regWdata[6]) |=> !resetPinOut_n)
		else $error("soft reset write did not pull reset");

	read_idle_a : assert property (@(posedge mclk) disable iff (!reset_n)
		!(regRead && regAddr == wdg_pkg::CTRL_ADDR) |=> regRdata == 8'h00)
		else $error("read data not zero when idle");

	pin_pair_a : assert property (@(posedge mclk) disable iff (!reset_n)
		resetPinOe == !resetPinOut_n)
		else $error("pin enable and level disagree");

	read_back_a : assert property (@(posedge mclk) disable iff (!reset_n)
		(regRead && regAddr == wdg_pkg::CTRL_ADDR)
		|=> regRdata == {$past(watchdog_activate_q), $past(counter_q)})
		else $error("read data wrong");

	timeout_c : cover property (@(posedge mclk) disable iff (!reset_n)
		watchdog_activate_q && $fell(counter_q[6]));
	hw_mode_c : cover property (@(posedge mclk) disable iff (!reset_n)
		hwWatchdog && $rose(resetPinOe));
	halt_c : cover property (@(posedge mclk) disable iff (!reset_n)
		haltReq);
	refresh_c : cover property (@(posedge mclk) disable iff (!reset_n)
		ctrlWrite && regWdata[7:6] == 2'b11);
endmodule

// >>> tb/reset_pin_model.sv
/*
 * Partner model: the chip reset pin with its pull-up.
 * Assumes the watchdog drives the pin only while its enable is high.
 */
`timescale 1ns/1ps
module reset_pin_model (
	input  wire logic driveLow_n, // Level driven by the watchdog.
	input  wire logic driveOe,    // High while the watchdog drives.
	output logic      pin         // Resolved pin level.
);
	// A released pin is pulled up, so it never shows the last driven value.
	assign pin = driveOe ? driveLow_n : 1'b1;
endmodule

// >>> tb/windowed_reset_watchdog_tb.sv
/*
 * Self-checking bench for the windowed reset watchdog.
 * Assumes short counts: eight cycles per counter step, five cycle reset pulse.
 */
`timescale 1ns/1ps
module windowed_reset_watchdog_tb;
	logic        mclk, reset_n, regWrite, regRead, haltExec, haltOpt, hwWatchdog;
	logic        outN, oe, pin;
	logic [7:0]  regAddr, regWdata, regRdata, d;
	int          fail_count, n_tests, k, len;
	// Each row: written byte in the top half, read-back byte in the low half.
	logic [15:0] rows [4] = '{16'h4040, 16'hc5c5, 16'h45c5, 16'hffff};

	windowed_reset_watchdog #(.PRESCALE(8), .PULSE(5)) DUT (.mclk(mclk), .reset_n(reset_n),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .haltExec(haltExec), .halt_reset_option(haltOpt),
		.hwWatchdog(hwWatchdog), .resetPinOut_n(outN), .resetPinOe(oe));
	reset_pin_model PIN (.driveLow_n(outN), .driveOe(oe), .pin(pin));

	initial begin
		mclk = 0;
		forever #4 mclk = ~mclk;
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task test_done();
		if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input logic [7:0] v);
		@(posedge mclk) {regWrite, regAddr, regWdata} <= {1'b1, 8'h00, v};
		@(posedge mclk) regWrite <= 0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge mclk) {regRead, regAddr} <= {1'b1, a};
		@(posedge mclk) regRead <= 0;
		#1 d = regRdata;
	endtask
	task halt();
		@(posedge mclk) haltExec <= 1;
		@(posedge mclk) haltExec <= 0;
	endtask
	// Waits a bounded time for the pin to fall, then counts the low cycles.
	task pulse(input int bound);
		len = 0;
		#1;
		for (k = 0; k < bound && pin !== 1'b0; k++) begin
			@(posedge mclk) #1;
		end
		while (pin === 1'b0 && len < 100) begin
			len++;
			@(posedge mclk) #1;
		end
	endtask

	initial begin
		{reset_n, regWrite, regRead, haltExec, haltOpt, hwWatchdog} = 0;
		{regAddr, regWdata, fail_count, n_tests} = 0;
		repeat (12) @(posedge mclk);
		reset_n <= 1;
		rd(8'h00);
		chk(d, 8'h7f, "reset value");
		chk({7'h0, pin}, 8'h01, "idle pin");
		rd(8'h01);
		chk(d, 8'h00, "unmapped read");
		foreach (rows[i]) begin
			wr(rows[i][15:8]);
			rd(8'h00);
			// The counter may step once between write and read.
			chk((d === rows[i][7:0] - 8'h01) ? rows[i][7:0] : d, rows[i][7:0], "readback");
		end
		wr(8'hc1);
		pulse(24);
		chk(len[7:0], 8'h05, "timeout pulse");
		wr(8'hff);
		wr(8'h80);
		pulse(6);
		chk(len[7:0], 8'h05, "soft reset");
		wr(8'hff);
		halt();
		pulse(4);
		chk(len[7:0], 8'h00, "halt option off");
		haltOpt <= 1;
		halt();
		pulse(4);
		chk(len[7:0], 8'h05, "halt reset");
		@(posedge mclk) reset_n <= 0;
		@(posedge mclk) reset_n <= 1;
		rd(8'h00);
		chk(d, 8'h7f, "mid-run reset");
		halt();
		pulse(600);
		chk(len[7:0], 8'h00, "inactive rollover");
		rd(8'h00);
		chk({6'h0, d[7:6]}, 8'h00, "free running");
		hwWatchdog <= 1;
		wr(8'h41);
		pulse(24);
		chk(len[7:0], 8'h05, "hardware mode");
		test_done();
	end

	initial begin
		#50000;
		fail_count++;
		test_done();
	end
endmodule
